//--- src/ram_ldst_defines.vh
// constants for the internal-ram load/store and byte-swap block
`ifndef RAM_LDST_DEFINES_VH
`define RAM_LDST_DEFINES_VH
`define OPC_MSB 31
`define OPC_LSB 26
`define OPC_LOAD_HALF 6'h10
`define OPC_LOAD_DOUBLE 6'h11
`define OPC_STORE_HALF 6'h12
`define OPC_STORE_DOUBLE 6'h13
`define RD_MSB 25
`define RD_LSB 20
`define RLA_MSB 18
`define RLA_LSB 16
`define LD_SWAP_MSB 11
`define LD_SWAP_LSB 10
`define ST_SWAP_MSB 21
`define ST_SWAP_LSB 20
`define ST_SRC_MSB 15
`define ST_SRC_LSB 10
`define ST_SRCB_MSB 5
`define ST_SRCB_LSB 0
`define IDX_MSB 9
`define IDX_LSB 5
`define SEL_SCOREBOARD_BIT 11
`define SEL_GATHER_BIT 10
`define PAIR_XOR 16'h0002
`define GATHER_BASE_A 16'h0400
`define GATHER_STEP 16'h0020
`define SWAP_BYTES_BIT 0
`define SWAP_HALVES_BIT 1
`endif

//--- src/byte_swapper.v
// byte and halfword reordering for one or two halfword operands
`default_nettype none
module byte_swapper (
	// operand
	input wire [31:0] data_i,
	input wire [1:0] swap_i,
	input wire dbl_i,
	// result
	output reg [31:0] data_o
);
	reg [31:0] b;
	always @* begin
		b = data_i;
		if (swap_i[0]) begin
			b = {data_i[23:16], data_i[31:24], data_i[7:0], data_i[15:8]};
		end
		// exchange halves only when there are two of them
		if (swap_i[1] && dbl_i) begin
			b = {b[15:0], b[31:16]};
		end
		data_o = b;
	end
endmodule // byte_swapper
`default_nettype wire

//--- src/ram_ldst_unit.v
// internal-ram load/store decoder with byte swap and load interlock
`include "ram_ldst_defines.vh"
// What this block does
// RULE1 - swap from bits 11:10 load, 21:20 store
// RULE2 - swap applies to all cell-buffer halfword transfers
// RULE3 - scoreboard swap result is undefined
// RULE4 - all four swap codes are legal
// RULE5 - code 00 unchanged, 01 bytes swapped per half
// RULE6 - code 11 double reverses all four bytes
// RULE7 - reorder on the memory data path
// RULE8 - single load writes one halfword to rd
// RULE9 - address from address register and index
// RULE10 - double fills rd+1 from address xor 2
// RULE11 - index bit 0 dropped, halfword aligned
// RULE12 - keep issuing, stall only on pending use
// RULE13 - software spaces loads and uses by two
// RULE14 - load fields at their fixed bit positions
// RULE15 - address xor index, bit 0 forced zero
// RULE16 - bit 11 scoreboard, bit 10 gather
// RULE17 - opcodes 010000 and 010001 are loads
// RULE18 - track each pending destination until return
`default_nettype none
module ram_ldst_unit #(
	parameter NREGS = 64
) (
	// clock and reset
	input wire clk_i,
	input wire rst_i,
	// issue from the pipeline
	input wire issue_i,
	input wire [31:0] instr_i,
	input wire [15:0] addr_reg_0_i,
	input wire [15:0] addr_reg_1_i,
	input wire [15:0] addr_reg_2_i,
	input wire [15:0] addr_reg_3_i,
	input wire [15:0] store_a_i,
	input wire [15:0] store_b_i,
	// source registers read by the next instruction
	input wire use_valid_i,
	input wire [5:0] use_a_i,
	input wire [5:0] use_b_i,
	// request to internal memory
	output reg mem_req_o,
	output reg mem_we_o,
	output reg mem_dbl_o,
	output reg mem_scoreboard_o,
	output reg mem_gather_o,
	output reg [15:0] mem_addr_o,
	output reg [15:0] mem_addr2_o,
	output reg [31:0] mem_wdata_o,
	output reg [5:0] mem_tag_o,
	output reg [1:0] mem_swap_o,
	// return from internal memory
	input wire ret_valid_i,
	input wire [5:0] ret_tag_i,
	input wire ret_dbl_i,
	input wire [1:0] ret_swap_i,
	input wire [31:0] ret_data_i,
	// register write-back
	output reg wb_valid_o,
	output reg [5:0] wb_reg_o,
	output reg [15:0] wb_data_o,
	output reg wb2_valid_o,
	output reg [5:0] wb2_reg_o,
	output reg [15:0] wb2_data_o,
	// interlock
	output wire stall_o
);
	reg [NREGS-1:0] pend_reg;
	reg [NREGS-1:0] pend_next;
	wire [5:0] opc = instr_i[`OPC_MSB:`OPC_LSB];
	wire is_ld = (opc == `OPC_LOAD_HALF) || (opc == `OPC_LOAD_DOUBLE); // [RULE17]
	wire is_st = (opc == `OPC_STORE_HALF) || (opc == `OPC_STORE_DOUBLE);
	wire is_dbl = (opc == `OPC_LOAD_DOUBLE) || (opc == `OPC_STORE_DOUBLE);
	wire [5:0] rd = instr_i[`RD_MSB:`RD_LSB]; // [RULE14]
	wire [5:0] rd1 = rd + 6'h01;
	wire [2:0] rla = instr_i[`RLA_MSB:`RLA_LSB]; // [RULE14]
	// all four codes decode; none raises an illegal-instruction case
	wire [1:0] swap = is_st ? instr_i[`ST_SWAP_MSB:`ST_SWAP_LSB]
		: instr_i[`LD_SWAP_MSB:`LD_SWAP_LSB]; // [RULE1] [RULE4]
	wire [4:0] idx = instr_i[`IDX_MSB:`IDX_LSB]; // [RULE14]
	reg [15:0] base;
	always @* begin
		case (rla)
			3'h0: base = addr_reg_0_i;
			3'h1: base = addr_reg_1_i;
			3'h2: base = addr_reg_2_i;
			3'h3: base = addr_reg_3_i;
			default: base = `GATHER_BASE_A + {11'h000, rla[1:0], 3'h0} *
				`GATHER_STEP / 16'h0008;
		endcase
	end
	// halfword index lands on bits 5:1; the byte bit 0 never reaches memory
	wire [15:0] tgt = (base ^ {10'h000, idx, 1'b0}) & 16'hfffe; // [RULE9] [RULE11] [RULE15]
	wire use_pend = use_valid_i && (pend_reg[use_a_i] || pend_reg[use_b_i]);
	// only a consumer of an outstanding register waits
	assign stall_o = use_pend; // [RULE12]
	wire fire = issue_i && !stall_o;
	wire [31:0] st_raw = {store_a_i, is_dbl ? store_b_i : 16'h0000};
	wire [31:0] st_sw;
	byte_swapper u_st_swap (
		.data_i(st_raw),
		.swap_i(swap),
		.dbl_i(is_dbl),
		.data_o(st_sw)
	); // [RULE7]
	wire [31:0] ld_sw;
	// scoreboard data goes through the same path; its swap result is
	// not promised to mean anything
	byte_swapper u_ld_swap (
		.data_i(ret_data_i),
		.swap_i(ret_swap_i),
		.dbl_i(ret_dbl_i),
		.data_o(ld_sw)
	); // [RULE2] [RULE3] [RULE5] [RULE6] [RULE7]
	always @* begin
		pend_next = pend_reg;
		if (ret_valid_i) begin
			pend_next[ret_tag_i] = 1'b0; // [RULE18]
			if (ret_dbl_i) begin
				pend_next[ret_tag_i + 6'h01] = 1'b0; // [RULE18]
			end
		end
		// a new load marks its targets after the release, so it wins
		if (fire && is_ld) begin
			pend_next[rd] = 1'b1; // [RULE18]
			if (is_dbl) begin
				pend_next[rd1] = 1'b1; // [RULE18]
			end
		end
	end
	always @(posedge clk_i) begin
		if (rst_i) begin
			pend_reg <= {NREGS{1'b0}};
			mem_req_o <= 1'b0;
			mem_we_o <= 1'b0;
			mem_dbl_o <= 1'b0;
			mem_scoreboard_o <= 1'b0;
			mem_gather_o <= 1'b0;
			mem_addr_o <= 16'h0000;
			mem_addr2_o <= 16'h0000;
			mem_wdata_o <= 32'h0000_0000;
			mem_tag_o <= 6'h00;
			mem_swap_o <= 2'h0;
			wb_valid_o <= 1'b0;
			wb_reg_o <= 6'h00;
			wb_data_o <= 16'h0000;
			wb2_valid_o <= 1'b0;
			wb2_reg_o <= 6'h00;
			wb2_data_o <= 16'h0000;
		end else begin
			pend_reg <= pend_next;
			mem_req_o <= fire && (is_ld || is_st);
			if (fire && (is_ld || is_st)) begin
				mem_we_o <= is_st;
				mem_dbl_o <= is_dbl;
				mem_scoreboard_o <= base[`SEL_SCOREBOARD_BIT]; // [RULE16]
				mem_gather_o <= base[`SEL_GATHER_BIT]; // [RULE16]
				mem_addr_o <= tgt; // [RULE8]
				mem_addr2_o <= tgt ^ `PAIR_XOR; // [RULE10]
				mem_wdata_o <= st_sw; // [RULE7]
				mem_tag_o <= rd;
				mem_swap_o <= swap;
			end
			wb_valid_o <= ret_valid_i;
			wb2_valid_o <= ret_valid_i && ret_dbl_i;
			if (ret_valid_i) begin
				wb_reg_o <= ret_tag_i;
				wb_data_o <= ld_sw[31:16]; // [RULE8]
				wb2_reg_o <= ret_tag_i + 6'h01;
				wb2_data_o <= ld_sw[15:0]; // [RULE10]
			end
		end
	end
endmodule // ram_ldst_unit
`default_nettype wire

//--- bench/ram_ldst_props.sv
// assertions on the load/store block ports
`default_nettype none
module ram_ldst_props (
	input wire logic clk_i, rst_i, issue_i, stall_o, mem_req_o, mem_we_o,
	input wire logic mem_dbl_o, ret_valid_i, ret_dbl_i, wb_valid_o,
	input wire logic wb2_valid_o,
	input wire logic [31:0] instr_i,
	input wire logic [15:0] mem_addr_o, mem_addr2_o,
	input wire logic [5:0] mem_tag_o, ret_tag_i, wb_reg_o,
	input wire logic [1:0] mem_swap_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	wire logic go = issue_i && !stall_o;
	wire logic [5:0] op = instr_i[31:26];
	ld_single_a: assert property (
		go && op == 6'h10 |=> mem_req_o && !mem_dbl_o && !mem_we_o)
		else $error("single load not requested");
	ld_double_a: assert property (
		go && op == 6'h11 |=> mem_req_o && mem_dbl_o)
		else $error("double load not requested");
	ld_swap_a: assert property (
		go && op[5:1] == 5'h08 |=> mem_swap_o == $past(instr_i[11:10]))
		else $error("load swap code wrong");
	st_swap_a: assert property (
		go && op[5:1] == 5'h09 |=> mem_we_o && mem_swap_o == $past(instr_i[21:20]))
		else $error("store swap code wrong");
	ld_tag_a: assert property (
		go && op[5:1] == 5'h08 |=> mem_tag_o == $past(instr_i[25:20]))
		else $error("load tag wrong");
	addr_even_a: assert property (mem_req_o |-> !mem_addr_o[0])
		else $error("odd target address");
	pair_addr_a: assert property (
		mem_req_o |-> mem_addr2_o == (mem_addr_o ^ 16'h0002))
		else $error("second address wrong");
	wb_return_a: assert property (ret_valid_i |=> wb_valid_o &&
		wb_reg_o == $past(ret_tag_i) && wb2_valid_o == $past(ret_dbl_i))
		else $error("write-back missing");
	stall_hold_a: assert property (issue_i && stall_o |=> !mem_req_o)
		else $error("stalled issue accepted");
endmodule // ram_ldst_props
`default_nettype wire

//--- bench/mem_model.sv
// internal memory model answering one load at a time
`default_nettype none
module mem_model (
	input wire logic clk_i, rst_i, req_i, dbl_i,
	input wire logic [5:0] tag_i,
	input wire logic [1:0] swap_i,
	input wire logic [3:0] lat_i,
	output logic vld_o = 1'b0, dbl_o = 1'b0,
	output logic [5:0] tag_o = 6'h00,
	output logic [1:0] swap_o = 2'h0,
	output logic [31:0] data_o = 32'h0000_0000
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] cnt = 4'h0;
	always @(posedge clk_i) begin
		vld_o <= 1'b0;
		// inverse pattern outside the return cycle so stale data is caught
		data_o <= 32'h55aa_4499;
		if (rst_i) cnt <= 4'h0;
		else if (req_i) begin
			cnt <= lat_i;
			tag_o <= tag_i;
			dbl_o <= dbl_i;
			swap_o <= swap_i;
		end else if (cnt != 4'h0) begin
			cnt <= cnt - 4'h1;
			if (cnt == 4'h1) begin
				vld_o <= 1'b1;
				data_o <= 32'haa55_bb66;
			end
		end
	end
endmodule // mem_model
`default_nettype wire

//--- bench/ram_ldst_unit_tb_top.sv
// bench for the internal-ram load/store block
`default_nettype none
module ram_ldst_unit_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i = 0, rst_i = 1, issue_i = 0, use_valid_i = 0, stall_o;
	logic ret_valid_i, ret_dbl_i, wb_valid_o, wb2_valid_o, mem_req_o;
	logic mem_dbl_o, mem_gather_o, mem_we_o, mem_scoreboard_o;
	logic [5:0] wb2_reg_o;
	logic [31:0] instr_i = 0, ret_data_i, mem_wdata_o;
	logic [15:0] ra0 = 16'h063d, mem_addr_o, wb_data_o, wb2_data_o;
	logic [5:0] use_b_i = 0, ret_tag_i, mem_tag_o;
	logic [1:0] ret_swap_i, mem_swap_o;
	logic [3:0] lat = 4'h1;
	logic [4:0] idx;
	int fails = 0, tests_run = 0;
	// swap codes 0..3 single then double: first and second halfword
	logic [31:0] exp [8] = '{32'haa55_0000, 32'h55aa_0000, 32'haa55_0000,
		32'h55aa_0000, 32'haa55_bb66, 32'h55aa_66bb, 32'hbb66_aa55,
		32'h66bb_55aa};
	always #50 clk_i = ~clk_i;
	ram_ldst_unit uut (.clk_i, .rst_i, .issue_i, .instr_i, .addr_reg_0_i(ra0),
		.addr_reg_1_i(16'h0800), .addr_reg_2_i(16'h0000),
		.addr_reg_3_i(16'h0000), .store_a_i(16'haa55), .store_b_i(16'hbb66),
		.use_valid_i, .use_a_i(use_b_i), .use_b_i, .mem_req_o, .mem_we_o,
		.mem_dbl_o, .mem_scoreboard_o, .mem_gather_o, .mem_addr_o,
		.mem_addr2_o(), .mem_wdata_o, .mem_tag_o, .mem_swap_o, .ret_valid_i,
		.ret_tag_i, .ret_dbl_i, .ret_swap_i, .ret_data_i, .wb_valid_o,
		.wb_reg_o(), .wb_data_o, .wb2_valid_o, .wb2_reg_o, .wb2_data_o,
		.stall_o);
	// stores are absorbed by the write side and give no return
	mem_model mem (.clk_i, .rst_i, .req_i(mem_req_o && !mem_we_o),
		.dbl_i(mem_dbl_o),
		.tag_i(mem_tag_o), .swap_i(mem_swap_o), .lat_i(lat),
		.vld_o(ret_valid_i), .dbl_o(ret_dbl_i), .tag_o(ret_tag_i),
		.swap_o(ret_swap_i), .data_o(ret_data_i));
	task chk(input logic ok);
		tests_run++;
		if (ok !== 1'b1) begin
			fails++;
			$display("unexpected at %0t: wrong output", $time);
		end
	endtask
	task automatic issue(input logic [31:0] ins);
		@(posedge clk_i);
		issue_i <= 1'b1;
		instr_i <= ins;
		@(posedge clk_i);
		issue_i <= 1'b0;
		#1;
	endtask
	task automatic await_wb;
		int k = 0;
		while (wb_valid_o !== 1'b1 && k < 20) begin
			@(posedge clk_i);
			#1 k++;
		end
		chk(k < 20);
	endtask
	task results;
		$display("checks %0d, mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	initial begin
		#200us;
		fails++;
		results;
	end
	initial begin
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		#1 chk(mem_req_o === 0 && wb_valid_o === 0 && stall_o === 0);
		for (int i = 0; i < 8; i++) begin
			idx = 5'(i * 7);
			issue({5'h08, i[2], 6'd2, 1'b0, i[0], 6'h00, i[1:0], idx, 5'h00});
			chk(mem_addr_o === (((i[0] ? 16'h0400 : ra0) ^ {idx, 1'b0}) & 16'hfffe));
			chk(mem_gather_o === 1'b1);
			await_wb;
			chk(wb_data_o === exp[i][31:16] && (i < 4 || wb2_data_o === exp[i][15:0]));
			chk(i < 4 || (wb2_valid_o === 1'b1 && wb2_reg_o === 6'd3));
		end
		issue({6'h10, 6'd3, 1'b0, 3'b001, 16'h0000});
		chk(mem_scoreboard_o === 1'b1 && mem_gather_o === 1'b0);
		chk(mem_we_o === 1'b0 && mem_addr_o === 16'h0800);
		await_wb;
		chk(wb2_valid_o === 1'b0);
		issue({6'h13, 4'h0, 2'b11, 1'b0, 3'b100, 16'h0000});
		chk(mem_wdata_o === 32'h66bb_55aa && mem_addr_o === 16'h0400);
		chk(mem_we_o === 1'b1);
		issue({6'h12, 4'h0, 2'b01, 1'b0, 3'b100, 16'h0000});
		chk(mem_wdata_o[31:16] === 16'h55aa);
		lat <= 4'h6;
		issue({6'h11, 6'd9, 1'b0, 3'b100, 16'h0000});
		@(posedge clk_i);
		issue_i <= 1'b1;
		use_valid_i <= 1'b1;
		use_b_i <= 6'd10;
		#1 chk(stall_o === 1'b1);
		await_wb;
		chk(stall_o === 1'b0);
		@(posedge clk_i);
		issue_i <= 1'b0;
		use_valid_i <= 1'b0;
		await_wb;
		results;
	end
endmodule // ram_ldst_unit_tb_top
bind ram_ldst_unit ram_ldst_props chk_u (.*);
`default_nettype wire
